/* rtl/link_power_defs.svh */
/*
  Constants for the copper link power saver: field positions, timer codes,
  and timing counts at the 250 MHz core clock.
  Assumes the includer uses the macros by bare name; definitions only.
*/
// Function
// R1: Per-port power saving enabled by bit 28.6
// R2: Alternate low power and wake-up without energy
// R3: Energy detected moves to normal operation
// R4: Autoneg link loss returns low after timeout
// R5: Reset starts in low power state
// R6: Forced speed: stay normal after energy
// R7: Autoneg disabled in normal: stay normal
// R8: Low power gates blocks, keeps management, monitors
// R9: Sleep timer 20E1.14:13, randomized -80/+60 ms
// R10: Wake-up sends up to three bursts, alternating
// R11: Management interface alive in wake-up state
// R12: After wake-up transmission return to low power
// R13: Link timeout set by bits 28.7, 28.2
// R14: Mode disabled holds normal operation always
`ifndef LINK_POWER_DEFS_SVH
`define LINK_POWER_DEFS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      4
`define CYC_PER_MS         (1000000 / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Register field positions
// ----------------------------------------------------------------
`define EN_BIT_POS         6
`define TMO_HI_POS         7
`define TMO_LO_POS         2
`define SLEEP_MSB          14
`define SLEEP_LSB          13
`define WAKE_MSB           12
`define WAKE_LSB           11

// ----------------------------------------------------------------
// Times in ms per two-bit code, reset codes, jitter, burst and LFSR settings
// ----------------------------------------------------------------
`define SLEEP_MS_0         1000
`define SLEEP_MS_1         2000
`define SLEEP_MS_2         3000
`define SLEEP_MS_3         4000
`define SLEEP_CODE_RST     2'h1
`define WAKE_MS_0          160
`define WAKE_MS_1          400
`define WAKE_MS_2          800
`define WAKE_MS_3          2000
`define WAKE_CODE_RST      2'h0
`define TMO_MS_0           1000
`define TMO_MS_1           2000
`define TMO_MS_2           3000
`define TMO_MS_3           4000
`define JIT_MINUS_MS       80
`define JIT_PLUS_MS        60
`define BURST_MAX          3
`define BURST_SPACING_MS   16
`define LFSR_SEED          16'hACE1

`endif

/* rtl/link_power_pkg.sv */
/*
  Types for the copper link power saver.
  Assumes the constants header is compiled alongside.
*/
package link_power_pkg;
  typedef enum logic [1:0] {
    LOW_POWER,
    PARTNER_WAKE,
    NORMAL_OP
  } power_state_t;
endpackage

/* rtl/auto_link_power_saving.sv */
/*
  Per-port automatic link power saving state machine.
  Assumes all inputs synchronous to sys_clk; timers are counted in ms ticks.
*/
`timescale 1ns/1ps
`include "link_power_defs.svh"
`default_nettype none
module auto_link_power_saving #(
  parameter int unsigned MS_CYCLES = `CYC_PER_MS      // Cycles per ms, shorten in sim
) (
  input  wire  logic                       sys_clk,         // Core clock, 250 MHz
  input  wire  logic                       arst_n,          // Async reset, active low
  input  wire  logic                       savingEnable,    // Reg bit 28.6
  input  wire  logic                       timeoutHi,       // Reg bit 28.7
  input  wire  logic                       timeoutLo,       // Reg bit 28.2
  input  wire  logic [1:0]                 sleepCode,       // Reg bits 20E1.14:13
  input  wire  logic [1:0]                 wakeCode,        // Reg bits 20E1.12:11
  input  wire  logic                       energyDetect,    // Media signal energy
  input  wire  logic                       autonegEnable,   // Autonegotiation on
  input  wire  logic                       linkUp,          // Link status
  output var   link_power_pkg::power_state_t powerState,    // Current state
  output logic                             blocksPowerDown, // Gate major digital blocks
  output logic                             burstStart,      // One-cycle burst trigger
  output logic                             burstPairB       // Pair for the burst, 1=B
);
  import link_power_pkg::*;

  // ----------------------------------------------------------------
  // Time tables
  // ----------------------------------------------------------------
  // Sleep time in ms for a code
  function automatic logic [12:0] sleepMs(input logic [1:0] c);
    unique case (c)
      2'h0: sleepMs = 13'(`SLEEP_MS_0);
      2'h1: sleepMs = 13'(`SLEEP_MS_1);
      2'h2: sleepMs = 13'(`SLEEP_MS_2);
      2'h3: sleepMs = 13'(`SLEEP_MS_3);
    endcase
  endfunction

  // Wake duration in ms for a code
  function automatic logic [12:0] wakeMs(input logic [1:0] c);
    unique case (c)
      2'h0: wakeMs = 13'(`WAKE_MS_0);
      2'h1: wakeMs = 13'(`WAKE_MS_1);
      2'h2: wakeMs = 13'(`WAKE_MS_2);
      2'h3: wakeMs = 13'(`WAKE_MS_3);
    endcase
  endfunction

  // Link time-out in ms from the split field
  function automatic logic [12:0] tmoMs(input logic [1:0] c);
    unique case (c)
      2'h0: tmoMs = 13'(`TMO_MS_0);
      2'h1: tmoMs = 13'(`TMO_MS_1);
      2'h2: tmoMs = 13'(`TMO_MS_2);
      2'h3: tmoMs = 13'(`TMO_MS_3);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  logic [31:0]  tickCnt;        // Cycle prescaler
  logic [31:0]  next_tickCnt;   // Next prescaler value
  logic         msTick;         // One ms elapsed

  // Free-running prescaler keeps all timers on one coarse tick
  always_comb begin
    msTick       = (tickCnt == 32'(MS_CYCLES - 1));
    next_tickCnt = msTick ? 32'h0 : tickCnt + 32'h1;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tickCnt <= 32'h0;
    end else begin
      tickCnt <= next_tickCnt;
    end
  end

  // ----------------------------------------------------------------
  // Random jitter source
  // ----------------------------------------------------------------
  logic [15:0]  lfsr;           // Pseudo-random state
  logic [15:0]  next_lfsr;      // Next LFSR value
  logic [7:0]   jitter;         // 0..140 ms offset above minimum

  // Runs every cycle so two ports drift apart; avoids lock-step sleeping
  always_comb begin
    next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    jitter    = (lfsr[7:0] > 8'(`JIT_MINUS_MS + `JIT_PLUS_MS))
              ? 8'(lfsr[7:0] - 8'(`JIT_MINUS_MS + `JIT_PLUS_MS + 1)) : lfsr[7:0];
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lfsr <= `LFSR_SEED;
    end else begin
      lfsr <= next_lfsr;
    end
  end

  // ----------------------------------------------------------------
  // State machine and timers
  // ----------------------------------------------------------------
  power_state_t state;          // Present state
  power_state_t next_state;     // Next state
  logic [12:0]  msLeft;         // Remaining ms in timed phase
  logic [12:0]  next_msLeft;    // Next remaining ms
  logic [12:0]  burstGap;       // ms until next burst
  logic [12:0]  next_burstGap;  // Next burst gap
  logic [1:0]   burstsSent;     // Bursts sent this wake-up
  logic [1:0]   next_burstsSent;// Next burst count
  logic         pairB;          // Pair of last burst
  logic         next_pairB;     // Next pair
  logic         stickyNormal;   // Stay normal despite link drop
  logic         next_stickyNormal; // Next sticky flag
  logic         linkLost;       // Timing a link loss
  logic         next_linkLost;  // Next link loss flag
  logic         fireBurst;      // Launch a burst this cycle

  always_comb begin
    next_state        = state;
    next_msLeft       = msLeft;
    next_burstGap     = burstGap;
    next_burstsSent   = burstsSent;
    next_pairB        = pairB;
    next_stickyNormal = stickyNormal;
    next_linkLost     = linkLost;
    fireBurst         = 1'b0;
    if (!savingEnable) begin                         // see R1
      next_state        = NORMAL_OP;                 // see R14
      next_linkLost     = 1'b0;
      next_stickyNormal = 1'b0;                      // Fresh start on re-enable
    end else begin
      unique case (state)
        LOW_POWER: begin
          if (energyDetect) begin
            next_state        = NORMAL_OP;           // see R3
            next_stickyNormal = !autonegEnable;      // see R6
            next_linkLost     = 1'b0;
          end else if (msTick) begin
            if (msLeft <= 13'h1) begin
              next_state      = PARTNER_WAKE;        // see R2
              next_msLeft     = wakeMs(wakeCode);    // see R10
              next_burstGap   = 13'h0;
              next_burstsSent = 2'h0;
            end else begin
              next_msLeft = msLeft - 13'h1;          // see R9
            end
          end
        end
        PARTNER_WAKE: begin
          if (energyDetect) begin
            next_state        = NORMAL_OP;           // see R3
            next_stickyNormal = !autonegEnable;      // see R6
            next_linkLost     = 1'b0;
          end else if (msTick) begin
            if (msLeft <= 13'h1) begin
              next_state  = LOW_POWER;               // see R12
              next_msLeft = 13'(sleepMs(sleepCode) - 13'(`JIT_MINUS_MS) + 13'(jitter)); // see R9
            end else begin
              next_msLeft = msLeft - 13'h1;
              if (burstGap == 13'h0 && burstsSent < 2'(`BURST_MAX)) begin
                fireBurst       = 1'b1;              // see R10
                next_burstsSent = burstsSent + 2'h1;
                next_pairB      = !pairB;
                next_burstGap   = 13'(`BURST_SPACING_MS);
              end else if (burstGap != 13'h0) begin
                next_burstGap = burstGap - 13'h1;
              end
            end
          end
        end
        NORMAL_OP: begin
          if (!autonegEnable) begin
            next_stickyNormal = 1'b1;                // see R7
          end
          if (linkUp || stickyNormal) begin
            next_linkLost = 1'b0;
          end else if (!linkLost) begin
            next_linkLost = 1'b1;
            next_msLeft   = tmoMs({timeoutHi, timeoutLo}); // see R13
          end else if (msTick) begin
            if (msLeft <= 13'h1) begin
              next_state    = LOW_POWER;             // see R4
              next_linkLost = 1'b0;
              next_msLeft   = 13'(sleepMs(sleepCode) - 13'(`JIT_MINUS_MS) + 13'(jitter));
            end else begin
              next_msLeft = msLeft - 13'h1;
            end
          end
        end
        default: next_state = LOW_POWER;             // Illegal code recovers to sleep
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state        <= LOW_POWER;                     // see R5
      msLeft       <= 13'(`SLEEP_MS_1);
      burstGap     <= 13'h0;
      burstsSent   <= 2'h0;
      pairB        <= 1'b1;
      stickyNormal <= 1'b0;
      linkLost     <= 1'b0;
    end else begin
      state        <= next_state;
      msLeft       <= next_msLeft;
      burstGap     <= next_burstGap;
      burstsSent   <= next_burstsSent;
      pairB        <= next_pairB;
      stickyNormal <= next_stickyNormal;
      linkLost     <= next_linkLost;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Registered so downstream power gates never glitch
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      powerState      <= LOW_POWER;
      blocksPowerDown <= 1'b1;
      burstStart      <= 1'b0;
      burstPairB      <= 1'b0;
    end else begin
      powerState      <= next_state;
      blocksPowerDown <= (next_state != NORMAL_OP);  // see R8 R11
      burstStart      <= fireBurst;
      burstPairB      <= next_pairB;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  disabled_normal_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R14
    !savingEnable |=> state == NORMAL_OP) else $error("Disabled mode left normal");
  energy_wakes_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R3
    savingEnable && state != NORMAL_OP && energyDetect |=> state == NORMAL_OP)
    else $error("Energy did not wake port");
  burst_only_wake_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R10
    burstStart |-> $past(state) == PARTNER_WAKE) else $error("Burst outside wake-up");
  burst_limit_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R10
    burstsSent == 2'(`BURST_MAX) |=> !burstStart) else $error("Too many bursts");
  burst_alternate_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R10
    burstStart |-> burstPairB != $past(pairB)) else $error("Pair did not alternate");
  gate_matches_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R8
    blocksPowerDown == (powerState != NORMAL_OP)) else $error("Gate mismatch");
  sticky_stays_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R7
    state == NORMAL_OP && stickyNormal && savingEnable |=> state == NORMAL_OP)
    else $error("Sticky normal left");
  wake_to_low_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R12
    state == PARTNER_WAKE && !energyDetect && savingEnable && msTick && msLeft <= 13'h1
    |=> state == LOW_POWER) else $error("Wake-up did not return low");
  low_timeout_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see R4
    state == NORMAL_OP && $past(state) == NORMAL_OP && linkLost && !linkUp && savingEnable
    && !stickyNormal && msTick && msLeft <= 13'h1 |=> state == LOW_POWER)
    else $error("Link timeout missed");

  wake_seen_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    state == LOW_POWER ##1 state == PARTNER_WAKE);
  burst_seen_c: cover property (@(posedge sys_clk) disable iff (!arst_n) burstStart);
  up_seen_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    state == PARTNER_WAKE ##1 state == NORMAL_OP);
  drop_seen_c: cover property (@(posedge sys_clk) disable iff (!arst_n)
    state == NORMAL_OP ##1 state == LOW_POWER);
endmodule
`default_nettype wire

/* test/link_partner_model.sv */
/*
  Far-side link partner: puts energy on our media pins and reports link.
  Assumes the bench clock and one-cycle burst triggers from the port.
*/
`timescale 1ns/1ps
`default_nettype none
module link_partner_model #(
  parameter int LAT = 40                // Cycles from burst to reply
) (
  input  wire logic sys_clk,            // Core clock
  input  wire logic plugged,            // Cable present
  input  wire logic awake,              // Partner sends on its own
  input  wire logic burstStart,         // Burst seen from our port
  output logic      energyDetect,       // Energy on our media pins
  output logic      linkUp              // Link status
);
  int   cnt;                            // Countdown after a burst
  logic woken;                          // Partner roused by a burst

  // ----------------------------------------------------------------
  // Reply logic
  // ----------------------------------------------------------------
  // A sleeping partner answers only LAT cycles after a burst, so the
  // port must keep cycling meanwhile; unplugging drops energy at once, link a cycle later
  always_ff @(posedge sys_clk) begin
    if (!plugged) begin
      cnt   <= 0;
      woken <= 1'b0;
    end else if (cnt != 0) begin
      cnt   <= cnt - 1;
      woken <= woken | (cnt == 1);
    end else if (burstStart) begin
      cnt <= LAT;
    end
    energyDetect <= plugged & (awake | woken);
    linkUp       <= energyDetect;       // Link lags energy one cycle
  end
endmodule
`default_nettype wire

/* test/copper_link_power_saver_tb.sv */
/*
  Self-checking bench for the link power saver with a partner model.
  Assumes the design's package and header are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module copper_link_power_saver_tb;
  import link_power_pkg::*;
  localparam int MS  = 8;               // Short ms tick keeps the run small
  localparam int LIM = 95000;           // Cycle ceiling for a hang
  logic sys_clk = 1'b0;                 // Core clock
  logic arst_n = 1'b0;                  // Reset, active low
  logic savingEnable = 1'b1;            // Mode enable
  logic timeoutHi = 1'b0;               // Time-out code high bit
  logic timeoutLo = 1'b0;               // Time-out code low bit
  logic [1:0] sleepCode = 2'h0;         // Sleep code
  logic [1:0] wakeCode = 2'h0;          // Wake code
  logic autonegEnable = 1'b1;           // Autonegotiation on
  logic plugged = 1'b0;                 // Cable present
  logic awake = 1'b0;                   // Partner active
  logic energyDetect, linkUp, blocksPowerDown, burstStart, burstPairB;
  power_state_t powerState;             // Design state
  int n_errors, comparisons, cycles;    // Counters

  always #2 sys_clk = ~sys_clk;

  auto_link_power_saving #(.MS_CYCLES(MS)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .savingEnable(savingEnable),
    .timeoutHi(timeoutHi), .timeoutLo(timeoutLo), .sleepCode(sleepCode),
    .wakeCode(wakeCode), .energyDetect(energyDetect), .autonegEnable(autonegEnable),
    .linkUp(linkUp), .powerState(powerState), .blocksPowerDown(blocksPowerDown),
    .burstStart(burstStart), .burstPairB(burstPairB));
  link_partner_model #(.LAT(40)) partner (
    .sys_clk(sys_clk), .plugged(plugged), .awake(awake), .burstStart(burstStart),
    .energyDetect(energyDetect), .linkUp(linkUp));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Every compare funnels here so nothing unknown slips through
  task automatic chk(string what, logic [1:0] exp, logic [1:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Let edges pass, then sample once outputs settle
  task automatic hold(int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask
  // Bounded wait for a state; n returns the edges taken
  task automatic wait_st(power_state_t st, int cap, output int n);
    n = 0;
    while (powerState !== st && n < cap) begin
      hold(1);
      n++;
    end
  endtask
  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIM) begin
      n_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    hold(6);
    chk("state in reset", LOW_POWER, powerState);
    chk("gating in reset", 2'h1, {1'b0, blocksPowerDown});
    @(posedge sys_clk);
    arst_n <= 1'b1;
    $display("test reset done");
  endtask
  // Sleep and wake times, burst count and pair order, no energy
  task automatic t_cycle();
    int n, len, nb, w;
    logic prev;
    wait_st(PARTNER_WAKE, 2100 * MS, n);
    chk("first sleep span", 2'h1, {1'b0, n >= 1999 * MS && n <= 2001 * MS});
    for (int k = 0; k < 2; k++) begin
      nb = 0;
      len = 0;
      w = (k == 0) ? 160 : 400;
      while (powerState === PARTNER_WAKE && len < 500 * MS) begin
        chk("gated in wake", 2'h1, {1'b0, blocksPowerDown});
        if (burstStart === 1'b1) begin
          if (nb > 0) chk("pair alternates", {1'b0, ~prev}, {1'b0, burstPairB});
          prev = burstPairB;
          nb++;
        end
        hold(1);
        len++;
      end
      chk("burst count", 2'h1, {1'b0, nb >= 1 && nb <= 3});
      chk("wake span", 2'h1, {1'b0, len >= (w - 1) * MS && len <= (w + 1) * MS});
      chk("back to low", LOW_POWER, powerState);
      if (k == 0) begin
        @(posedge sys_clk);
        wakeCode <= 2'h1;
        wait_st(PARTNER_WAKE, 1100 * MS, n);
        chk("sleep span", 2'h1, {1'b0, n >= 919 * MS && n <= 1061 * MS});
      end
    end
    $display("test cycle done");
  endtask
  // A sleeping partner is woken by our bursts, then drops the link
  task automatic t_drop();
    int n;
    @(posedge sys_clk);
    plugged <= 1'b1;
    timeoutLo <= 1'b1;
    wait_st(NORMAL_OP, 1300 * MS, n);
    chk("woken to normal", NORMAL_OP, powerState);
    hold(20);
    @(posedge sys_clk);
    plugged <= 1'b0;
    hold(1999 * MS);
    chk("still normal", NORMAL_OP, powerState);
    wait_st(LOW_POWER, 5 * MS, n);
    chk("low after timeout", LOW_POWER, powerState);
    $display("test drop done");
  endtask
  // Forced speed: prompt energy, then link loss keeps normal
  task automatic t_forced();
    @(posedge sys_clk);
    timeoutLo <= 1'b0;
    autonegEnable <= 1'b0;
    plugged <= 1'b1;
    awake <= 1'b1;
    hold(2);
    chk("energy to normal", NORMAL_OP, powerState);
    chk("ungated", 2'h0, {1'b0, blocksPowerDown});
    @(posedge sys_clk);
    plugged <= 1'b0;
    hold(1050 * MS);
    chk("forced stays", NORMAL_OP, powerState);
    $display("test forced done");
  endtask
  // Mode off holds normal; autoneg turned off in normal keeps it there
  task automatic t_modes();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    hold(2);
    chk("state in mid reset", LOW_POWER, powerState);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    savingEnable <= 1'b0;
    hold(50);
    chk("mode off", NORMAL_OP, powerState);
    @(posedge sys_clk);
    savingEnable <= 1'b1;
    autonegEnable <= 1'b1;
    plugged <= 1'b1;
    hold(10);
    chk("enable in normal", NORMAL_OP, powerState);
    @(posedge sys_clk);
    autonegEnable <= 1'b0;
    plugged <= 1'b0;
    hold(1050 * MS);
    chk("autoneg off stays", NORMAL_OP, powerState);
    $display("test modes done");
  endtask

  initial begin
    t_reset();
    t_cycle();
    t_drop();
    t_forced();
    t_modes();
    final_report();
  end
endmodule
`default_nettype wire
